// *** hdl/cirx_pkg.sv ***
// Package for the indirect-store and return instruction executor
package cirx_pkg;

  // ****************************************************************
  // Register map (byte addresses on the AHB-Lite slave)
  // ****************************************************************
  localparam logic [7:0] CIRX_CMD_OFS       = 8'h00;
  localparam logic [7:0] CIRX_ACC_OFS       = 8'h04;
  localparam logic [7:0] CIRX_PTR0_OFS      = 8'h08;
  localparam logic [7:0] CIRX_PTR1_OFS      = 8'h0C;
  localparam logic [7:0] CIRX_PC_OFS        = 8'h10;
  localparam logic [7:0] CIRX_STACK_TOP_OFS = 8'h14;
  localparam logic [7:0] CIRX_OPTION_OFS    = 8'h18;
  localparam logic [7:0] CIRX_INT_CTRL_OFS  = 8'h1C;
  localparam logic [7:0] CIRX_PWR_CTRL_OFS  = 8'h20;
  localparam logic [7:0] CIRX_STATUS_OFS    = 8'h24;

  // ****************************************************************
  // Command word fields: [3:0] opcode, [4] pointer select,
  // [6:5] addressing mode code, [13:8] signed offset
  // ****************************************************************
  localparam int CIRX_OP_LSB   = 0;
  localparam int CIRX_PSEL_BIT = 4;
  localparam int CIRX_MODE_LSB = 5;
  localparam int CIRX_OFS_LSB  = 8;

  localparam logic [3:0] CIRX_OP_NOP      = 4'h0;
  localparam logic [3:0] CIRX_OP_STORE    = 4'h1;
  localparam logic [3:0] CIRX_OP_STORE_K  = 4'h2;
  localparam logic [3:0] CIRX_OP_OPTION   = 4'h3;
  localparam logic [3:0] CIRX_OP_RESET    = 4'h4;
  localparam logic [3:0] CIRX_OP_RETFROMI = 4'h5;
  localparam logic [3:0] CIRX_OP_RETURN   = 4'h6;

  localparam logic [1:0] CIRX_MODE_PREINC  = 2'h0;
  localparam logic [1:0] CIRX_MODE_PREDEC  = 2'h1;
  localparam logic [1:0] CIRX_MODE_POSTINC = 2'h2;
  localparam logic [1:0] CIRX_MODE_POSTDEC = 2'h3;

  localparam int CIRX_GLOBAL_IE_BIT = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  CIRX_OPTION_RST   = 8'hFF;
  localparam logic [7:0]  CIRX_INT_CTRL_RST = 8'h00;
  localparam logic [15:0] CIRX_PC_RST       = 16'h0000;
  localparam logic        CIRX_RIFLAG_RST   = 1'b1;
  localparam int          CIRX_RET_CYCLES   = 2;

  typedef enum logic [1:0] {
    CIRX_IDLE = 2'b00,
    CIRX_RET2 = 2'b01
  } cirx_state_e;

endpackage

// *** hdl/cirx_core.sv ***
// Executor for indirect store, option load, reset and return instructions
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module cirx_core
  import cirx_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Data memory write port
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  // Device reset request and stack pop
  output logic             soft_reset,
  output logic             stack_pop
);

  typedef struct packed {
    cirx_state_e st;
    logic [7:0]  wr_addr;
    logic        wr_pend;
    logic [7:0]  acc;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] pc;
    logic [15:0] stack_top;
    logic [7:0]  option;
    logic [7:0]  int_ctrl;
    logic        ri_flag;
    logic [7:0]  status;
    logic [31:0] rdata;
    logic        we;
    logic [15:0] maddr;
    logic [7:0]  wdata;
    logic        srst;
    logic        pop;
  } cirx_regs_s;

  cirx_regs_s q_reg;
  cirx_regs_s q_next;

  // Pin reset image; the software reset reuses it, but clears the reset source flag
  localparam cirx_regs_s CIRX_REGS_RST = '{
    st:       CIRX_IDLE,
    option:   CIRX_OPTION_RST,
    int_ctrl: CIRX_INT_CTRL_RST,
    pc:       CIRX_PC_RST,
    ri_flag:  CIRX_RIFLAG_RST,
    default:  '0
  };

  // Sign-extend a 6-bit offset to pointer width
  function automatic logic [15:0] cirx_sext(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [3:0]  op;
    logic [1:0]  md;
    logic        psel;
    logic [15:0] ptr;
    logic [15:0] upd;
    op = hwdata[CIRX_OP_LSB +: 4];
    md = hwdata[CIRX_MODE_LSB +: 2];
    psel = hwdata[CIRX_PSEL_BIT];
    ptr = psel ? q_reg.ptr1 : q_reg.ptr0;
    // 16-bit add/sub wraps at both ends of the range
    upd = md[0] ? ptr - 16'h0001 : ptr + 16'h0001;
    q_next = q_reg;
    q_next.we = 1'b0;
    q_next.srst = 1'b0;
    q_next.pop = 1'b0;
    // Second cycle of a return completes the jump
    if (q_reg.st == CIRX_RET2) begin
      q_next.st = CIRX_IDLE;
      q_next.pc = q_reg.stack_top;
    end
    if (q_reg.wr_pend) begin
      q_next.wr_pend = 1'b0;
      unique case (q_reg.wr_addr)
        CIRX_ACC_OFS:       q_next.acc = hwdata[7:0];
        CIRX_PTR0_OFS:      q_next.ptr0 = hwdata[15:0];
        CIRX_PTR1_OFS:      q_next.ptr1 = hwdata[15:0];
        CIRX_PC_OFS:        q_next.pc = hwdata[15:0];
        CIRX_STACK_TOP_OFS: q_next.stack_top = hwdata[15:0];
        CIRX_INT_CTRL_OFS:  q_next.int_ctrl = hwdata[7:0];
        CIRX_PWR_CTRL_OFS:  q_next.ri_flag = hwdata[0];
        CIRX_STATUS_OFS:    q_next.status = hwdata[7:0];
        CIRX_CMD_OFS: begin
          q_next.pc = q_reg.pc + 16'h0001;
          unique case (op)
            CIRX_OP_STORE: begin
              q_next.we = 1'b1;
              q_next.maddr = md[1] ? ptr : upd;
              q_next.wdata = q_reg.acc;
              // Status left alone on pointer update
              if (psel) q_next.ptr1 = upd;
              else q_next.ptr0 = upd;
            end
            CIRX_OP_STORE_K: begin
              q_next.we = 1'b1;
              q_next.maddr = ptr +
                cirx_sext(hwdata[CIRX_OFS_LSB +: 6]);
              q_next.wdata = q_reg.acc;
            end
            CIRX_OP_OPTION: q_next.option = q_reg.acc;
            CIRX_OP_RESET: begin
              // Whole local state as after the pin reset, but the
              // source flag reads low so software can tell them apart
              q_next = CIRX_REGS_RST;
              q_next.ri_flag = 1'b0;
              q_next.srst = 1'b1;
            end
            CIRX_OP_RETFROMI: begin
              q_next.int_ctrl[CIRX_GLOBAL_IE_BIT] = 1'b1;
              q_next.pop = 1'b1;
              q_next.st = CIRX_RET2;
            end
            CIRX_OP_RETURN: begin
              q_next.pop = 1'b1;
              q_next.st = CIRX_RET2;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      q_next.wr_addr = haddr[7:0];
      q_next.wr_pend = hwrite;
      if (!hwrite) begin
        unique case (haddr[7:0])
          CIRX_ACC_OFS:       q_next.rdata = {24'h000000, q_reg.acc};
          CIRX_PTR0_OFS:      q_next.rdata = {16'h0000, q_reg.ptr0};
          CIRX_PTR1_OFS:      q_next.rdata = {16'h0000, q_reg.ptr1};
          CIRX_PC_OFS:        q_next.rdata = {16'h0000, q_reg.pc};
          CIRX_STACK_TOP_OFS: q_next.rdata = {16'h0000, q_reg.stack_top};
          CIRX_OPTION_OFS:    q_next.rdata = {24'h000000, q_reg.option};
          CIRX_INT_CTRL_OFS:  q_next.rdata = {24'h000000, q_reg.int_ctrl};
          CIRX_PWR_CTRL_OFS:  q_next.rdata = {31'h0, q_reg.ri_flag};
          CIRX_STATUS_OFS:    q_next.rdata = {24'h000000, q_reg.status};
          CIRX_CMD_OFS:       q_next.rdata = {31'h0,
                                              q_reg.st == CIRX_RET2};
          default:            q_next.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_reg <= CIRX_REGS_RST;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata = q_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_we = q_reg.we;
  assign mem_addr = q_reg.maddr;
  assign mem_wdata = q_reg.wdata;
  assign soft_reset = q_reg.srst;
  assign stack_pop = q_reg.pop;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ret_two_cycle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && q_reg.pop) |-> (q_reg.st == CIRX_RET2))
    else $error("return did not enter second cycle");
  a_ret_int_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && q_reg.wr_pend && q_reg.wr_addr == CIRX_CMD_OFS
      && hwdata[CIRX_OP_LSB +: 4] == CIRX_OP_RETFROMI)
      |=> (q_reg.int_ctrl[CIRX_GLOBAL_IE_BIT] && q_reg.pop))
    else $error("interrupt return left the enable clear");
  a_ret_pc_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && q_reg.st == CIRX_RET2 && !q_reg.wr_pend)
      |=> q_reg.pc == $past(q_reg.stack_top))
    else $error("pc not loaded from top of stack");
  a_reset_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q_reg.srst |-> !q_reg.ri_flag)
    else $error("reset flag not cleared");
  a_reset_option: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q_reg.srst |-> q_reg.option == CIRX_OPTION_RST)
    else $error("option not reset");
  a_store_data: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q_reg.we |-> q_reg.wdata == q_reg.acc)
    else $error("store data not accumulator");
  a_status_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && q_reg.wr_pend && q_reg.wr_addr != CIRX_STATUS_OFS
      && !(q_reg.wr_addr == CIRX_CMD_OFS
        && hwdata[CIRX_OP_LSB +: 4] == CIRX_OP_RESET))
      |=> $stable(q_reg.status))
    else $error("status changed");
  a_store_wrap: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (q_reg.we && q_reg.ptr0 == 16'h0000 && $past(q_reg.ptr0) == 16'hFFFF
      && $past(clk_en)) |-> q_reg.maddr inside {16'h0000, 16'hFFFF})
    else $error("pointer did not wrap");
  a_option_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && q_reg.wr_pend && q_reg.wr_addr == CIRX_CMD_OFS
      && hwdata[CIRX_OP_LSB +: 4] == CIRX_OP_OPTION)
      |=> q_reg.option == $past(q_reg.acc))
    else $error("option not loaded from accumulator");

endmodule

// *** dv/cirx_core_tb.sv ***
// Self-checking testbench for the instruction executor over AHB-Lite
`timescale 1ns/1ps
module cirx_core_tb
  import cirx_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        soft_reset;
  logic        stack_pop;
  int          fails = 0;
  int          cmp_count = 0;
  int          we_n = 0;
  int          sr_n = 0;
  int          sp_n = 0;
  logic [15:0] ma;
  logic [7:0]  md;
  logic [31:0] rd_s;
  logic        rdy_s;
  logic        resp_s;
  logic [31:0] r;

  always #25 hclk = ~hclk;

  cirx_core u_cirx_core (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .soft_reset(soft_reset),
    .stack_pop(stack_pop));

  // Values as the slave showed them just before each edge
  always @(posedge hclk) begin
    rd_s  <= hrdata;
    rdy_s <= hreadyout;
    resp_s <= hresp;
  end

  // Pulses last one cycle, so the falling edge sees each exactly once
  always @(negedge hclk) begin
    if (mem_we === 1'b1) begin
      we_n++;
      ma = mem_addr;
      md = mem_wdata;
    end
    if (soft_reset === 1'b1) sr_n++;
    if (stack_pop === 1'b1) sp_n++;
  end

  // ****************************************************************
  // Bus access and comparison tasks
  // ****************************************************************
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("Error at %0t: bus wait timed out", $time);
      complete_run();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = rd_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, exp);
    chk({31'h0, resp_s}, 32'h0);
  endtask

  // Store through a pointer, then check address, data, pointer, flags
  task automatic st(input logic [7:0] po, input logic [15:0] init,
                    input logic [31:0] cmd, input logic [15:0] ea,
                    input logic [15:0] ef, input logic [7:0] acc);
    wr(po, {16'h0, init});
    wr(CIRX_ACC_OFS, {24'h0, acc});
    we_n = 0;
    wr(CIRX_CMD_OFS, cmd);
    rc(po, {16'h0, ef});
    chk(we_n, 1);
    chk({ma, md}, {ea, acc});
    rc(CIRX_STATUS_OFS, 32'h0000_0003);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  logic [15:0] m_ea [4] = '{16'h0001, 16'hFFFF, 16'h0000, 16'h0000};
  logic [15:0] m_ef [4] = '{16'h0001, 16'hFFFF, 16'h0001, 16'hFFFF};

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(CIRX_OPTION_OFS, 32'h0000_00FF);
    rc(CIRX_INT_CTRL_OFS, 32'h0000_0000);
    rc(CIRX_PC_OFS, 32'h0000_0000);
    rc(CIRX_PWR_CTRL_OFS, 32'h0000_0001);
    wr(8'h30, 32'h0000_00AA);
    rc(8'h30, 32'h0000_0000);
    $display("Test reset values done");
    wr(CIRX_STATUS_OFS, 32'h0000_0003);
    for (int m = 0; m < 4; m++) begin
      st(CIRX_PTR1_OFS, 16'h0000, 32'h11 | (m << 5), m_ea[m],
         m_ef[m], 8'(8'h80 + m));
    end
    st(CIRX_PTR0_OFS, 16'hFFFF, 32'h01, 16'h0000, 16'h0000, 8'h5A);
    st(CIRX_PTR0_OFS, 16'h1000, 32'h2002, 16'h0FE0, 16'h1000, 8'hC3);
    st(CIRX_PTR1_OFS, 16'h1000, 32'h1F12, 16'h101F, 16'h1000, 8'h3C);
    $display("Test indirect store done");
    wr(CIRX_PC_OFS, 32'h0000_0010);
    we_n = 0;
    wr(CIRX_CMD_OFS, {28'h0, CIRX_OP_NOP});
    rc(CIRX_PC_OFS, 32'h0000_0011);
    chk(we_n, 0);
    rc(CIRX_STATUS_OFS, 32'h0000_0003);
    // A command sent while the enable is low must not run
    clk_en <= 1'b0;
    wr(CIRX_CMD_OFS, {28'h0, CIRX_OP_NOP});
    clk_en <= 1'b1;
    rc(CIRX_PC_OFS, 32'h0000_0011);
    wr(CIRX_ACC_OFS, 32'h0000_004F);
    wr(CIRX_CMD_OFS, {28'h0, CIRX_OP_OPTION});
    rc(CIRX_OPTION_OFS, 32'h0000_004F);
    rc(CIRX_STATUS_OFS, 32'h0000_0003);
    $display("Test nop and option done");
    wr(CIRX_STACK_TOP_OFS, 32'h0000_1234);
    wr(CIRX_CMD_OFS, {28'h0, CIRX_OP_RETURN});
    rc(CIRX_CMD_OFS, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    rc(CIRX_PC_OFS, 32'h0000_1234);
    rc(CIRX_INT_CTRL_OFS, 32'h0000_0000);
    wr(CIRX_STACK_TOP_OFS, 32'h0000_0ABC);
    wr(CIRX_CMD_OFS, {28'h0, CIRX_OP_RETFROMI});
    rc(CIRX_CMD_OFS, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    rc(CIRX_PC_OFS, 32'h0000_0ABC);
    rc(CIRX_INT_CTRL_OFS, 32'h0000_0080);
    chk(sp_n, 2);
    rc(CIRX_STATUS_OFS, 32'h0000_0003);
    $display("Test returns done");
    wr(CIRX_CMD_OFS, {28'h0, CIRX_OP_RESET});
    repeat (2) @(posedge hclk);
    chk(sr_n, 1);
    rc(CIRX_PWR_CTRL_OFS, 32'h0000_0000);
    rc(CIRX_OPTION_OFS, 32'h0000_00FF);
    rc(CIRX_INT_CTRL_OFS, 32'h0000_0000);
    rc(CIRX_STATUS_OFS, 32'h0000_0000);
    rc(CIRX_PC_OFS, 32'h0000_0000);
    $display("Test software reset done");
    complete_run();
  end

  initial begin
    #2000000;
    fails++;
    $display("Error at %0t: run timed out", $time);
    complete_run();
  end
endmodule
